// File: core/cms_core.sv
// processor memory share, address decode, phase shaping and watchdog
`timescale 1ns/1ps
module cms_core (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         hcount_bit2,
	input  wire logic                         cpu_phi2,
	input  wire logic [cms_pkg::CPU_AW-1:0]   cpu_addr,
	input  wire logic                         cpu_rw,
	input  wire logic [cms_pkg::DATA_W-1:0]   cpu_data_i,
	output logic      [cms_pkg::DATA_W-1:0]   cpu_data_o,
	output logic                              cpu_data_oe,
	output logic                              phi0,
	output logic      [cms_pkg::ROM_DEVS-1:0] rom_ce_n,
	output logic                              wdog_clr,
	output logic                              cpu_reset_n,
	input  wire logic                         line_stb,
	input  wire logic [8:0]                   vid_hcount,
	input  wire logic [8:0]                   vid_vcount,
	output logic      [cms_pkg::DATA_W-1:0]   vid_data,
	input  wire logic                         prog_ld_we,
	input  wire logic [cms_pkg::ROM_AW-1:0]   prog_ld_addr,
	input  wire logic [cms_pkg::DATA_W-1:0]   prog_ld_data
);
	localparam int DEV_W = cms_pkg::DEV_HI - cms_pkg::DEV_LO + 1;

	logic                           h_q1_q;
	logic                           h_q2_q;
	logic                           phi2_prev_q;
	logic                           phi2_rise;
	logic [4:0]                     dec_field;
	logic                           ram_hit;
	logic                           rom_hit;
	logic                           wdog_hit;
	logic [DEV_W-1:0]               rom_dev;
	logic                           wr_gate;
	logic                           wr_q;
	logic                           cpu_we_n;
	logic                           ram_sel_n;
	logic [cms_pkg::RAM_AW-1:0]     scan_addr;
	logic [cms_pkg::MUX_W-1:0]      mux_out;
	logic                           ram_we;
	logic [cms_pkg::DATA_W-1:0]     ram_rdata;
	logic                           rom_we;
	logic [cms_pkg::ROM_AW-1:0]     rom_addr;
	logic [cms_pkg::DATA_W-1:0]     rom_rdata;
	logic [cms_pkg::DATA_W-1:0]     cpu_data_o_q;
	logic [cms_pkg::DATA_W-1:0]     vid_data_q;
	logic                           wdog_clr_q;
	logic [8:0]                     line_q;
	logic                           frame_tick;
	logic [3:0]                     frames_q;
	logic                           wdog_fire;
	logic                           cpu_reset_n_q;

	// base clock shaping
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			h_q1_q <= 1'b0;
			h_q2_q <= 1'b0;
		end else begin
			h_q1_q <= hcount_bit2;
			h_q2_q <= h_q1_q;
		end
	end
	assign phi0 = h_q1_q | h_q2_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phi2_prev_q <= 1'b0;
		end else begin
			phi2_prev_q <= cpu_phi2;
		end
	end
	// phase 1 is only the inverse of phase 2, so edges of phase 2 suffice
	assign phi2_rise = cpu_phi2 & ~phi2_prev_q;

	// address decode on bits 9..13
	assign dec_field = cpu_addr[cms_pkg::DEC_HI:cms_pkg::DEC_LO];
	assign ram_hit   = (dec_field == cms_pkg::RAM_CODE) ||
	                   (dec_field == cms_pkg::RAM_CODE_B);
	assign wdog_hit  = (dec_field == cms_pkg::WDOG_CODE);
	assign rom_hit   = cpu_addr[cms_pkg::ROM_SEL_BIT];
	assign rom_dev   = cpu_addr[cms_pkg::DEV_HI:cms_pkg::DEV_LO];

	genvar gi;
	generate
		for (gi = 0; gi < cms_pkg::ROM_DEVS; gi++) begin : g_rom_ce
			assign rom_ce_n[gi] = ~(rom_hit &&
				(rom_dev == DEV_W'(gi)));
		end
	endgenerate

	// write strobe retimed: first phase 2 clock only arms it, so the
	// processor's address and data have settled before any write lands
	assign wr_gate = cpu_phi2 & ~cpu_rw & ram_hit;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= wr_gate;
		end
	end
	assign cpu_we_n  = ~(wr_gate & wr_q);
	assign ram_sel_n = ~ram_hit;

	// twelve-pole switch: select, write and ten address lines
	assign scan_addr = {vid_vcount[cms_pkg::SCAN_HI:cms_pkg::SCAN_LO],
	                    vid_hcount[cms_pkg::SCAN_HI:cms_pkg::SCAN_LO]};
	assign mux_out = cpu_phi2 ?
		{ram_sel_n, cpu_we_n, cpu_addr[cms_pkg::RAM_AW-1:0]} :
		{1'b0, 1'b1, scan_addr};
	// write only when both select and write line are low
	assign ram_we = ~mux_out[cms_pkg::MUX_W-1] &
	                ~mux_out[cms_pkg::MUX_W-2];

	cms_mem #(
		.AW (cms_pkg::RAM_AW),
		.DW (cms_pkg::DATA_W)
	) u_ram (
		.clk     (clk),
		.rst_n   (rst_n),
		.we      (ram_we),
		.addr    (mux_out[cms_pkg::RAM_AW-1:0]),
		.wdata   (cpu_data_i),
		.rdata_q (ram_rdata)
	);

	// program store filled only from the loader port, never the bus
	assign rom_we   = prog_ld_we;
	assign rom_addr = prog_ld_we ? prog_ld_addr :
	                  cpu_addr[cms_pkg::ROM_AW-1:0];

	cms_mem #(
		.AW (cms_pkg::ROM_AW),
		.DW (cms_pkg::DATA_W)
	) u_rom (
		.clk     (clk),
		.rst_n   (rst_n),
		.we      (rom_we),
		.addr    (rom_addr),
		.wdata   (prog_ld_data),
		.rdata_q (rom_rdata)
	);

	// processor read path and bus driver
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_data_o_q <= '0;
		end else begin
			cpu_data_o_q <= rom_hit ? rom_rdata : ram_rdata;
		end
	end
	assign cpu_data_o  = cpu_data_o_q;
	assign cpu_data_oe = cpu_phi2 & cpu_rw & (ram_hit | rom_hit);

	// video output register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vid_data_q <= '0;
		end else if (phi2_rise) begin
			vid_data_q <= ram_rdata;
		end
	end
	assign vid_data = vid_data_q;

	// watchdog clear pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog_clr_q <= 1'b0;
		end else begin
			wdog_clr_q <= phi2_rise & wdog_hit;
		end
	end
	assign wdog_clr = wdog_clr_q;

	// line count within a frame
	assign frame_tick = line_stb && (line_q == cms_pkg::LINE_LAST);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= '0;
		end else if (frame_tick) begin
			line_q <= '0;
		end else if (line_stb) begin
			line_q <= line_q + 9'h001;
		end
	end

	// frame counter: a clear restarts the window, so it beats a tick
	assign wdog_fire = (frames_q == cms_pkg::WDOG_LIMIT);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frames_q <= '0;
		end else if (wdog_clr_q || wdog_fire) begin
			frames_q <= '0;
		end else if (frame_tick) begin
			frames_q <= (frames_q == cms_pkg::DECADE_LAST) ?
			            4'h0 : frames_q + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_reset_n_q <= 1'b1;
		end else begin
			cpu_reset_n_q <= ~wdog_fire;
		end
	end
	assign cpu_reset_n = cpu_reset_n_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wr_req;
		cpu_phi2 && !cpu_rw && ram_hit;
	endsequence

	sequence s_wr_armed;
		s_wr_req ##1 s_wr_req;
	endsequence

	phase_or_a: assert property (
		$past(h_q1_q) |-> phi0 ##0 $past(hcount_bit2, 2))
		else $error("phase 0 not the OR of the two stages");

	rom_one_ce_a: assert property (
		$countones(~rom_ce_n) == (rom_hit ? 1 : 0))
		else $error("wrong number of program memory enables");

	rom_ro_a: assert property (
		rom_we |-> prog_ld_we)
		else $error("program memory written from the bus");

	wr_lands_a: assert property (
		s_wr_armed |-> ram_we)
		else $error("settled write did not reach the RAM");

	wr_inside_a: assert property (
		ram_we |-> cpu_phi2 && $past(cpu_phi2) && !cpu_rw)
		else $error("RAM write outside settled phase 2");

	scan_read_a: assert property (
		!cpu_phi2 |-> !ram_we &&
		mux_out[cms_pkg::RAM_AW-1:0] == scan_addr)
		else $error("scan side not addressing the RAM");

	vid_latch_a: assert property (
		phi2_rise |=> vid_data === $past(ram_rdata))
		else $error("video register missed phase 2 edge");

	bus_drive_a: assert property (
		cpu_data_oe |-> cpu_phi2 && cpu_rw)
		else $error("data bus driven outside a read");

	wdog_clr_a: assert property (
		phi2_rise && wdog_hit |=> wdog_clr ##1 !wdog_clr)
		else $error("watchdog access gave no single clear pulse");

	wdog_fire_a: assert property (
		frames_q == cms_pkg::WDOG_LIMIT |=> !cpu_reset_n && frames_q == 0)
		else $error("eighth frame did not reset the processor");

	frame_len_a: assert property (
		frame_tick |=> line_q == 9'h000)
		else $error("frame length not held");
endmodule

// File: core/cms_mem.sv
// single-port memory with registered read data
`timescale 1ns/1ps
module cms_mem #(
	parameter int AW = 10,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// contents hold no reset: volatile like the parts it models
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= mem[addr];
		end
	end
endmodule

// File: inc/cms_pkg.sv
// constants for the processor memory share and watchdog block
// Behaviour
// - read-only program memory returns 8192 bytes; bus writes never alter it
// - read/write memory holds 1024 bytes, volatile
// - read/write memory reads while write select high, writes only while low
// - decoder looks at address bits 9..13, enables only the addressed ROM
// - RAM range decode with write indication drives active-low RAM select
// - write stores data-in at address A0..A9 while strobe and select low
// - base clock is hcount_bit2 through two flops, outputs ORed together
// - write strobe gated and retimed so writes land inside phase 2
// - 12-bit address mux gives processor the RAM while phase 2 high
// - while phase 2 low scan counters address RAM for video reads
// - RAM output register captures data on each phase 2 rising edge
// - bus drivers drive when disable low, float when disable high
// - access to watchdog address emits a watchdog clear pulse
// - frames counted; eight frames without clear resets the processor
// - one frame is 262 scan lines
package cms_pkg;
	localparam int          DATA_W      = 8;
	localparam int          CPU_AW      = 16;
	localparam int          ROM_AW      = 13;
	localparam int          RAM_AW      = 10;
	localparam int          MUX_W       = 12;
	localparam int          ROM_DEVS    = 4;
	localparam int          DEC_LO      = 9;
	localparam int          DEC_HI      = 13;
	localparam int          ROM_SEL_BIT = 13;
	localparam int          DEV_LO      = 11;
	localparam int          DEV_HI      = 12;
	localparam int          SCAN_LO     = 3;
	localparam int          SCAN_HI     = 7;
	localparam logic [4:0]  RAM_CODE    = 5'h00;
	localparam logic [4:0]  RAM_CODE_B  = 5'h01;
	localparam logic [4:0]  WDOG_CODE   = 5'h02;
	localparam logic [8:0]  LINE_LAST   = 9'h105;
	localparam logic [3:0]  WDOG_LIMIT  = 4'h8;
	localparam logic [3:0]  DECADE_LAST = 4'h9;
endpackage

// File: verif/cms_core_test.sv
// self-checking bench for the memory share and watchdog block
`timescale 1ns/1ps
module cms_core_test;
	localparam logic [3:0][15:0] RAM_A = {16'h02aa, 16'h0155, 16'h03ff,
	                                      16'h0000};
	logic        clk, rst_n, hcount_bit2, cpu_phi2, cpu_rw, phi0;
	logic        cpu_data_oe, wdog_clr, cpu_reset_n, line_stb, scan_run;
	logic        prog_ld_we, s1_q, s2_q, oe;
	logic [15:0] cpu_addr;
	logic [7:0]  cpu_data_i, cpu_data_o, vid_data, prog_ld_data, q;
	logic [8:0]  vid_hcount, vid_vcount;
	logic [3:0]  rom_ce_n, ce;
	logic [12:0] prog_ld_addr;
	int          n_errors, n_checks, n_strobe, n_clr, n_rst;
	int          rst_at [2];

	cms_core u_cms_core (.clk, .rst_n, .hcount_bit2, .cpu_phi2, .cpu_addr,
		.cpu_rw, .cpu_data_i, .cpu_data_o, .cpu_data_oe, .phi0, .rom_ce_n,
		.wdog_clr, .cpu_reset_n, .line_stb, .vid_hcount, .vid_vcount,
		.vid_data, .prog_ld_we, .prog_ld_addr, .prog_ld_data);
	cms_far_model u_cms_far_model (.clk, .rst_n, .phi0, .scan_run,
		.hcount_bit2, .cpu_phi2, .line_stb, .vid_hcount, .vid_vcount);

	task end_of_test;
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wait_phi(input logic lvl);
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			#1;
			if (cpu_phi2 === lvl)
				return;
		end
		chk("phase2", lvl, ~lvl);
	endtask

	// one bus transfer; address parked on an unmapped place afterwards
	task cycle(input logic [15:0] a, input logic rd, input logic [7:0] d);
		wait_phi(1'b0);
		cpu_addr = a;
		cpu_rw = rd;
		cpu_data_i = d;
		wait_phi(1'b1);
		repeat (3) @(posedge clk);
		#1;
		q = cpu_data_o;
		oe = cpu_data_oe;
		ce = rom_ce_n;
		wait_phi(1'b0);
		cpu_rw = 1'b1;
		cpu_addr = 16'h0600;
		cpu_data_i = ~d;
	endtask

	task test_rom;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			#1;
			prog_ld_we = 1'b1;
			prog_ld_addr = 13'(k * 2048 + k);
			prog_ld_data = 8'(8'ha0 + k);
		end
		@(posedge clk);
		#1;
		prog_ld_we = 1'b0;
		for (int k = 0; k < 4; k++) begin
			cycle(16'h2000 + 16'(k * 2048 + k), 1'b0, 8'h55);
			cycle(16'h2000 + 16'(k * 2048 + k), 1'b1, 8'h00);
			chk("rom_data", 8'(8'ha0 + k), q);
			chk("rom_oe", 1'b1, oe);
			chk("rom_ce_n", 4'(~(4'h1 << k)), ce);
		end
	endtask

	task test_ram;
		for (int i = 0; i < 4; i++)
			cycle(RAM_A[i], 1'b0, RAM_A[i][7:0] ^ 8'h3c);
		for (int i = 0; i < 4; i++) begin
			cycle(RAM_A[i], 1'b1, 8'h00);
			chk("ram_data", RAM_A[i][7:0] ^ 8'h3c, q);
			chk("ram_ce_n", 4'hf, ce);
		end
		cycle(16'h0600, 1'b1, 8'h00);
		chk("free_oe", 1'b0, oe);
		// scan parked at zero: next phase 2 rise latches that byte
		wait_phi(1'b1);
		wait_phi(1'b0);
		wait_phi(1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk("vid_data", 8'h3c, vid_data);
	endtask

	task test_wdog;
		scan_run = 1'b1;
		for (int i = 0; i < 5000 && n_strobe < 1310; i++)
			@(posedge clk);
		cycle(16'h0400, 1'b1, 8'h00);
		for (int i = 0; i < 20000 && n_rst < 2; i++)
			@(posedge clk);
		chk("wdog_clr", 16'd1, 16'(n_clr));
		chk("reset_1", 16'd3406, 16'(rst_at[0]));
		chk("reset_2", 16'd5502, 16'(rst_at[1]));
	endtask

	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			{s1_q, s2_q} <= 2'h0;
		else
			{s1_q, s2_q} <= {hcount_bit2, s1_q};

	always @(negedge clk) begin
		if (rst_n)
			chk("phi0", s1_q | s2_q, phi0);
		if (cpu_reset_n === 1'b0 && n_rst < 2) begin
			rst_at[n_rst] = n_strobe;
			n_rst++;
		end
		if (line_stb === 1'b1)
			n_strobe++;
		if (wdog_clr === 1'b1)
			n_clr++;
	end

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		cpu_addr = 16'h0600;
		cpu_rw = 1'b1;
		cpu_data_i = 8'h00;
		prog_ld_we = 1'b0;
		prog_ld_addr = 13'h0000;
		prog_ld_data = 8'h00;
		scan_run = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		test_rom;
		test_ram;
		test_wdog;
		end_of_test;
	end

	// whole run is about 11200 cycles
	initial begin
		#3000000;
		n_errors++;
		end_of_test;
	end
endmodule

// File: verif/cms_far_model.sv
// processor phase and scan counter model facing the memory block
`timescale 1ns/1ps
module cms_far_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       phi0,
	input  wire logic       scan_run,
	output logic            hcount_bit2,
	output logic            cpu_phi2,
	output logic            line_stb,
	output logic      [8:0] vid_hcount,
	output logic      [8:0] vid_vcount
);
	logic [2:0] div_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q    <= 3'h0;
			cpu_phi2 <= 1'b0;
		end else begin
			div_q    <= div_q + 3'h1;
			cpu_phi2 <= phi0;
		end
	end
	assign hcount_bit2 = div_q[2];
	// scan frozen until asked, so video reads hit a known address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_stb   <= 1'b0;
			vid_hcount <= 9'h000;
			vid_vcount <= 9'h000;
		end else if (scan_run) begin
			line_stb   <= ~line_stb;
			vid_hcount <= vid_hcount + 9'h001;
			vid_vcount <= vid_vcount + {8'h00, line_stb};
		end
	end
endmodule
